// >>> pll_lock_map.svh
// Function
// - sticky loss-of-lock flag sits at status bit 7, set once lock lost
// - sticky flag sets only when a held lock drifts out of tolerance
// - interrupt request from the sticky flag only when its enable is set
// - reset request from the sticky flag only when its enable is set
// - sticky flag clears on reset or on writing 1 while set
// - writing 0 to the sticky bit leaves it unchanged
// - live lock indicator at status bit 6, 1 while locked
// - lock detection runs only while loop enabled by mode or force bit
// - loop output clock gated off until the lock indicator asserts
// - divider or multiplier change clears lock until it is reacquired
// - reference clock loss clears lock until it is reacquired
// - deep stop entry, or stop without stop enable, clears lock
// - after re-enable, output clock stays gated until lock asserts again
`ifndef PLL_LOCK_MAP_SVH
`define PLL_LOCK_MAP_SVH

// register indexes; byte address is four times the index
`define IDX_REF_DIV    6'h00
`define IDX_VCO_MUL    6'h01
`define IDX_CTRL       6'h02
`define IDX_STATUS     6'h06
`define IDX_EVT_STAT   6'h08
`define IDX_EVT_CLR    6'h09
`define IDX_EVT_EN     6'h0a

// field layout
`define FIELD_W        5
`define STAT_STICKY    7
`define STAT_LOCK      6
`define CTRL_W         3
`define CTRL_RST_EN    0
`define CTRL_FORCE_EN  1
`define CTRL_STOP_EN   2
`define EVT_W          2
`define EVT_LOST       0
`define EVT_ACQ        1

// reset values
`define FIELD_RST      5'h00
`define CTRL_RST       3'h0
`define EVT_RST        2'h0
`define DATA_RST       32'h0000_0000

`endif

// >>> pll_lock_pkg.sv
package pll_lock_pkg;

   // lock tracking states, one-hot
   typedef enum logic [2:0] {
      ST_OFF     = 3'b001,
      ST_LOCKING = 3'b010,
      ST_LOCKED  = 3'b100
   } lock_state_t;

   // kind of stop mode being entered
   typedef enum logic [1:0] {
      STOP_NORMAL = 2'h0,
      STOP_LLS    = 2'h1,
      STOP_VERY_LOW_POWER_STOP   = 2'h2
   } stop_kind_t;

endpackage : pll_lock_pkg

// >>> lock_if.sv
interface lock_if;
   logic detect_en;
   logic in_band;
   logic force_clear;
   logic locked;
   logic lost_evt;
   logic acq_evt;

   modport tracker (input  detect_en, in_band, force_clear,
                    output locked, lost_evt, acq_evt);
   modport flags   (input  lost_evt, acq_evt);
   modport ctrl    (output detect_en, in_band, force_clear,
                    input  locked);
endinterface : lock_if

// >>> lock_tracker.sv
`include "pll_lock_map.svh"

module lock_tracker
   import pll_lock_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // lock signals
   lock_if.tracker  lk
);

   lock_state_t state_q;
   lock_state_t state_d;
   logic        lost_q;
   logic        acq_q;
   logic        lost_d;
   logic        acq_d;

   // next state of the lock tracker
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            if (lk.detect_en) state_d = ST_LOCKING;
         end
         ST_LOCKING: begin
            if (!lk.detect_en) state_d = ST_OFF;
            else if (!lk.force_clear && lk.in_band) state_d = ST_LOCKED;
         end
         ST_LOCKED: begin
            if (!lk.detect_en) state_d = ST_OFF;
            else if (lk.force_clear || !lk.in_band) begin
               state_d = ST_LOCKING;
            end
         end
         default: state_d = ST_OFF;
      endcase
   end

   // forced clears and switch-off are not losses, only drift is
   assign lost_d = (state_q == ST_LOCKED) && lk.detect_en &&
                   !lk.force_clear && !lk.in_band;
   assign acq_d  = (state_q == ST_LOCKING) && (state_d == ST_LOCKED);

   // state and event pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_OFF;
         lost_q  <= 1'b0;
         acq_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         lost_q  <= lost_d;
         acq_q   <= acq_d;
      end
   end

   assign lk.locked   = (state_q == ST_LOCKED);
   assign lk.lost_evt = lost_q;
   assign lk.acq_evt  = acq_q;

endmodule : lock_tracker

// >>> event_flags.sv
`include "pll_lock_map.svh"

module event_flags
   import pll_lock_pkg::*;
(
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // lock events
   lock_if.flags                   lk,
   // software controls
   input  wire logic               sticky_w1c,
   input  wire logic [`EVT_W-1:0]  evt_clr,
   input  wire logic [`EVT_W-1:0]  evt_en,
   // state
   output logic      [`EVT_W-1:0]  evt_stat,
   output logic                    irq
);

   logic [`EVT_W-1:0] evt_q;
   logic [`EVT_W-1:0] evt_d;
   logic [`EVT_W-1:0] evt_set;
   logic [`EVT_W-1:0] evt_kill;
   logic              irq_q;

   // sticky bit 0 is the loss-of-lock flag itself
   assign evt_set  = {lk.acq_evt, lk.lost_evt};
   assign evt_kill = evt_clr | {1'b0, sticky_w1c};
   // a set in the clearing cycle wins, so no loss goes unseen
   assign evt_d    = evt_set | (evt_q & ~evt_kill);

   // sticky flags and the level interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_q <= `EVT_RST;
         irq_q <= 1'b0;
      end else begin
         evt_q <= evt_d;
         irq_q <= |(evt_d & evt_en);
      end
   end

   assign evt_stat = evt_q;
   assign irq      = irq_q;

endmodule : event_flags

// >>> pll_lock_status_monitor.sv
// Added by the designer: the APB slave port.
`include "pll_lock_map.svh"

module pll_lock_status_monitor
   import pll_lock_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // analogue loop and mode control
   input  wire logic        lock_in_band,
   input  wire logic        mode_loop_enable,
   input  wire logic        ref_clock_lost,
   input  wire logic        stop_entry,
   input  wire stop_kind_t  stop_kind,
   // outputs
   output logic             loop_clock_enable,
   output logic             reset_request,
   output logic             irq
);

   // byte address match for a register index
   function automatic logic reg_hit(input logic [7:0] a,
                                    input logic [5:0] idx);
      reg_hit = (a == {idx, 2'b00});
   endfunction : reg_hit

   logic [`FIELD_W-1:0] ref_div_q;
   logic [`FIELD_W-1:0] vco_mul_q;
   logic [`CTRL_W-1:0]  ctrl_q;
   logic [`EVT_W-1:0]   evt_en_q;
   logic [31:0]         prdata_q;
   logic                pready_q;
   logic                pslverr_q;
   logic                clk_en_q;
   logic                rst_req_q;
   logic [`EVT_W-1:0]   evt_stat;
   logic                irq_w;

   wire hit_ref   = reg_hit(paddr, `IDX_REF_DIV);
   wire hit_vco   = reg_hit(paddr, `IDX_VCO_MUL);
   wire hit_ctrl  = reg_hit(paddr, `IDX_CTRL);
   wire hit_stat  = reg_hit(paddr, `IDX_STATUS);
   wire hit_evts  = reg_hit(paddr, `IDX_EVT_STAT);
   wire hit_evtc  = reg_hit(paddr, `IDX_EVT_CLR);
   wire hit_evte  = reg_hit(paddr, `IDX_EVT_EN);
   wire mapped    = hit_ref | hit_vco | hit_ctrl | hit_stat |
                    hit_evts | hit_evtc | hit_evte;

   // apb phases: answer is zero-wait, write lands at the access edge
   wire setup     = psel & ~penable;
   wire wr        = psel & penable & pready_q & pwrite & mapped;
   wire wr_ref    = wr & hit_ref;
   wire wr_vco    = wr & hit_vco;
   wire wr_ctrl   = wr & hit_ctrl;
   wire wr_stat   = wr & hit_stat;
   wire wr_evtc   = wr & hit_evtc;
   wire wr_evte   = wr & hit_evte;

   lock_if lk ();

   // divider or multiplier change restarts lock acquisition
   wire div_change = (wr_ref && pwdata[`FIELD_W-1:0] != ref_div_q) ||
                     (wr_vco && pwdata[`FIELD_W-1:0] != vco_mul_q);
   // deep stops always drop the loop; normal stop only without stop enable
   wire stop_drop  = stop_entry &&
                     (stop_kind != STOP_NORMAL || !ctrl_q[`CTRL_STOP_EN]);

   assign lk.detect_en   = mode_loop_enable |
                           ctrl_q[`CTRL_FORCE_EN];
   assign lk.in_band     = lock_in_band;
   assign lk.force_clear = div_change | ref_clock_lost |
                           stop_drop;

   // status register image
   wire [7:0] status_img = {evt_stat[`EVT_LOST], lk.locked,
                            6'h00};

   // read data selection
   wire [31:0] rd_data =
      hit_ref  ? {27'h0, ref_div_q} :
      hit_vco  ? {27'h0, vco_mul_q} :
      hit_ctrl ? {29'h0, ctrl_q} :
      hit_stat ? {24'h0, status_img} :
      hit_evts ? {30'h0, evt_stat} :
      hit_evte ? {30'h0, evt_en_q} :
      `DATA_RST;

   lock_tracker u_tracker (
      .pclk    (pclk),
      .presetn (presetn),
      .lk      (lk.tracker)
   );

   event_flags u_flags (
      .pclk       (pclk),
      .presetn    (presetn),
      .lk         (lk.flags),
      .sticky_w1c (wr_stat & pwdata[`STAT_STICKY]),
      .evt_clr    (wr_evtc ? pwdata[`EVT_W-1:0] : `EVT_RST),
      .evt_en     (evt_en_q),
      .evt_stat   (evt_stat),
      .irq        (irq_w)
   );

   // bus response flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= `DATA_RST;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~mapped;
         if (setup) prdata_q <= rd_data;
      end
   end

   // software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_div_q <= `FIELD_RST;
         vco_mul_q <= `FIELD_RST;
         ctrl_q    <= `CTRL_RST;
         evt_en_q  <= `EVT_RST;
      end else begin
         if (wr_ref)  ref_div_q <= pwdata[`FIELD_W-1:0];
         if (wr_vco)  vco_mul_q <= pwdata[`FIELD_W-1:0];
         if (wr_ctrl) ctrl_q    <= pwdata[`CTRL_W-1:0];
         if (wr_evte) evt_en_q  <= pwdata[`EVT_W-1:0];
      end
   end

   // output clock gate follows lock, reset request the sticky flag, one flop each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_en_q  <= 1'b0;
         rst_req_q <= 1'b0;
      end else begin
         clk_en_q  <= lk.locked;
         rst_req_q <= evt_stat[`EVT_LOST] &
                      ctrl_q[`CTRL_RST_EN];
      end
   end

   assign prdata            = prdata_q;
   assign pready            = pready_q;
   assign pslverr           = pslverr_q;
   assign loop_clock_enable = clk_en_q;
   assign reset_request     = rst_req_q;
   assign irq               = irq_w;

endmodule : pll_lock_status_monitor

// >>> pll_lock_props_properties.sv
`include "pll_lock_map.svh"

module pll_lock_props
   import pll_lock_pkg::*;
(
   // clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // apb
   input wire logic       psel,
   input wire logic       penable,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   // loop side
   input wire logic       lock_in_band,
   input wire logic       ref_clock_lost,
   input wire logic       stop_entry,
   input wire stop_kind_t stop_kind,
   input wire logic       loop_clock_enable,
   input wire logic       irq,
   input wire logic       reset_request
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // word decode, unaligned bytes never driven by the bench
   wire logic [5:0] word_ix = paddr[7:2];
   wire logic       map_hit = word_ix inside {`IDX_REF_DIV, `IDX_VCO_MUL,
      `IDX_CTRL, `IDX_STATUS, `IDX_EVT_STAT, `IDX_EVT_CLR, `IDX_EVT_EN};

   chk_ready_follows: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_unmapped_err: assert property (pready |-> pslverr == !map_hit)
      else $error("slave error does not match decode");
   chk_gate_lock: assert property (
      $rose(loop_clock_enable) |-> $past(lock_in_band, 2))
      else $error("clock ungated without lock");
   chk_loss_gate: assert property (
      loop_clock_enable && !lock_in_band |-> ##2 !loop_clock_enable)
      else $error("clock kept after loss");
   chk_ref_gate: assert property (
      ref_clock_lost |-> ##2 !loop_clock_enable)
      else $error("clock kept after reference loss");
   chk_stop_gate: assert property (
      stop_entry && stop_kind != STOP_NORMAL |-> ##2 !loop_clock_enable)
      else $error("clock kept after deep stop");
   chk_reset_quiet: assert property (
      $past(!presetn) |-> !loop_clock_enable && !irq && !reset_request)
      else $error("outputs active after reset");
endmodule : pll_lock_props

// >>> tb_pll_lock_status_monitor.sv
`include "pll_lock_map.svh"

module tb_pll_lock_status_monitor
   import pll_lock_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, er, lce, rreq, irq;
   logic        band = 0, mode = 0, refl = 0, stp = 0;
   stop_kind_t  kind = STOP_NORMAL;
   int          miscompares = 0, compares = 0;
   int          lk = 0, st = 0, acq = 0, ctl = 0, en = 0;
   int          ix[7] = '{`IDX_REF_DIV, `IDX_VCO_MUL, `IDX_CTRL,
                          `IDX_STATUS, `IDX_EVT_STAT, `IDX_EVT_EN, 4};

   always #4 pclk = ~pclk;

   pll_lock_status_monitor dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .lock_in_band(band), .mode_loop_enable(mode),
      .ref_clock_lost(refl), .stop_entry(stp), .stop_kind(kind),
      .loop_clock_enable(lce), .reset_request(rreq), .irq(irq));

   task automatic close_out;
      if (miscompares == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out

   task automatic check(input string nm, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : check

   // one apb transfer; the wait for ready is bounded
   task automatic apb(input bit w, input int i, input int d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= 8'(i * 4);
      pwdata  <= 32'(d);
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 9);
      // a hang counts a mismatch here; the verdict still comes at the end
      if (pready !== 1'b1) check("pready", 0, 1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // model against registers and pins
   task automatic cmp_all;
      apb(0, `IDX_STATUS, 0);
      check("status", rd, st * 128 + lk * 64);
      apb(0, `IDX_EVT_STAT, 0);
      check("evt_stat", rd, st + acq * 2);
      check("clock_en", lce, lk);
      check("irq", irq, |(en & (st + acq * 2)));
      check("reset_req", rreq, st & ctl & 1);
   endtask : cmp_all

   // detector settles well within six edges
   task automatic band_to(input bit b);
      band <= b;
      repeat (6) @(posedge pclk);
      if (b && !lk) acq = 1;
      if (!b && lk) st = 1;
      lk = b;
   endtask : band_to

   initial begin
      rd = $urandom(15);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ix[i]) begin
         apb(0, ix[i], 0);
         check("reset_val", rd, 0);
         check("slverr", er, ix[i] == 4);
      end
      // detection off, then forced on, then dropped without loss
      band <= 1'b1;
      repeat (6) @(posedge pclk);
      cmp_all();
      ctl = 2;
      apb(1, `IDX_CTRL, ctl);
      repeat (6) @(posedge pclk);
      {lk, acq} = {32'd1, 32'd1};
      cmp_all();
      ctl = 0;
      apb(1, `IDX_CTRL, ctl);
      // let detection fall first, else the mode handover sees a real loss
      repeat (2) @(posedge pclk);
      band <= 1'b0;
      mode <= 1'b1;
      lk = 0;
      repeat (6) @(posedge pclk);
      cmp_all();
      band_to(1);
      en = 3;
      apb(1, `IDX_EVT_EN, en);
      ctl = 1;
      apb(1, `IDX_CTRL, ctl);
      acq = 0;
      apb(1, `IDX_EVT_CLR, 2);
      band_to(0);
      cmp_all();
      apb(1, `IDX_STATUS, 32'h0000_007f);
      cmp_all();
      st = 0;
      apb(1, `IDX_STATUS, 32'h0000_0080);
      cmp_all();
      // loss with both requests masked
      {en, ctl, acq} = {32'd2, 32'd0, 32'd0};
      apb(1, `IDX_EVT_EN, en);
      apb(1, `IDX_CTRL, ctl);
      band_to(1);
      apb(1, `IDX_EVT_CLR, 2);
      acq = 0;
      band_to(0);
      cmp_all();
      st = 0;
      apb(1, `IDX_EVT_CLR, 1);
      // forced clears; band drops right after, so no loss if cleared
      for (int k = 0; k < 6; k++) begin
         band_to(1);
         if (k < 2)
            apb(1, k, 1 + $urandom % 31);
         else begin
            refl <= (k == 2);
            stp  <= (k > 2);
            kind <= stop_kind_t'(k == 3 ? 1 : k == 4 ? 2 : 0);
            @(posedge pclk);
         end
         refl <= 1'b0;
         stp  <= 1'b0;
         band <= 1'b0;
         repeat (6) @(posedge pclk);
         lk = 0;
         cmp_all();
      end
      // normal stop with the stop enable set keeps lock
      ctl = 4;
      apb(1, `IDX_CTRL, ctl);
      band_to(1);
      stp <= 1'b1;
      @(posedge pclk);
      stp <= 1'b0;
      band_to(0);
      cmp_all();
      close_out();
   end
endmodule : tb_pll_lock_status_monitor

bind pll_lock_status_monitor pll_lock_props chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .lock_in_band(lock_in_band),
   .ref_clock_lost(ref_clock_lost), .stop_entry(stop_entry),
   .stop_kind(stop_kind), .loop_clock_enable(loop_clock_enable),
   .irq(irq), .reset_request(reset_request));
